//--- hdl/omc_map.vh
`ifndef OMC_MAP_VH
`define OMC_MAP_VH
// Register offsets
`define OMC_ADDR_ADDITIONAL_CONTROL 7'h07
`define OMC_ADDR_BYPASS_ATTENUATION 7'h28
`define OMC_ADDR_SPEAKER_MIXER 7'h32
`define OMC_ADDR_SPEAKER_VOLUME 7'h36
`define OMC_ADDR_MONO_MIXER 7'h38
// Reset values
`define OMC_RST_ADDITIONAL_CONTROL 9'h000
`define OMC_RST_BYPASS_ATTENUATION 9'h000
`define OMC_RST_SPEAKER_MIXER 9'h001
`define OMC_RST_SPEAKER_VOLUME 9'h039
`define OMC_RST_MONO_MIXER 9'h001
// Field positions
`define OMC_BIT_SLOW_TICK_ENABLE 0
`define OMC_BIT_SPK_BYPASS_ATTEN 1
`define OMC_BIT_MONO_BYPASS_ATTEN 2
`define OMC_BIT_SPK_DAC_SEL 0
`define OMC_BIT_SPK_BYPASS_SEL 1
`define OMC_BIT_SPK_SECOND_MICROPHONE_INPUT_SEL 5
`define OMC_BIT_SPK_SILENCE 6
`define OMC_BIT_SPK_CROSSING 7
`define OMC_GAIN_MSB 5
`define OMC_BIT_MONO_DAC_SEL 0
`define OMC_BIT_MONO_BYPASS_SEL 1
`define OMC_BIT_MONO_SECOND_MICROPHONE_INPUT_SEL 2
`define OMC_BIT_MONO_SILENCE 6
// Timing counts in master clock periods
`define OMC_TIMEOUT_PERIODS 32'h0020_0000
`define OMC_SLOW_TICK_PERIODS 32'h0020_0000
`endif

//--- hdl/omc_crossing_update.v
`include "omc_map.vh"

module omc_crossing_update #(
  parameter integer TIMEOUT_CYCLES = `OMC_TIMEOUT_PERIODS,
  parameter integer CNT_W = 22
) (
  input wire ref_clk,
  input wire rst_n,
  input wire gain_write,
  input wire [5:0] gain_written,
  input wire crossing_only,
  input wire timeout_run,
  input wire sample_valid,
  input wire sample_sign,
  output reg [5:0] gain_applied_reg,
  output reg pending_reg
);
  localparam integer LAST_INT = TIMEOUT_CYCLES - 1;
  localparam [CNT_W-1:0] LAST_COUNT = LAST_INT[CNT_W-1:0];
  localparam [8:0] VOL_RESET = `OMC_RST_SPEAKER_VOLUME;
  reg [5:0] gain_pending_reg;
  reg [CNT_W-1:0] wait_count_reg;
  reg last_sign_reg;
  wire crossing;
  wire timed_out;

  assign crossing = sample_valid && (sample_sign != last_sign_reg);
  assign timed_out = timeout_run && (wait_count_reg == LAST_COUNT);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_applied_reg <= VOL_RESET[`OMC_GAIN_MSB:0];
      gain_pending_reg <= VOL_RESET[`OMC_GAIN_MSB:0];
      pending_reg <= 1'b0;
      wait_count_reg <= {CNT_W{1'b0}};
      last_sign_reg <= 1'b0;
    end else begin
      if (sample_valid) begin
        last_sign_reg <= sample_sign;
      end
      if (gain_write) begin
        if (crossing_only) begin
          gain_pending_reg <= gain_written;
          pending_reg <= 1'b1;
          wait_count_reg <= {CNT_W{1'b0}};
        end else begin
          gain_applied_reg <= gain_written;
          pending_reg <= 1'b0;
        end
      end else if (pending_reg) begin
        if (!crossing_only || crossing || timed_out) begin
          gain_applied_reg <= gain_pending_reg;
          pending_reg <= 1'b0;
        end else if (timeout_run) begin
          wait_count_reg <= wait_count_reg + 1'b1;
        end
      end
    end
  end
endmodule // omc_crossing_update

//--- hdl/omc_output_mixer.v
`include "omc_map.vh"

// Overview of operation
// - Speaker mixer sources: DAC, bypass, second mic
// - Speaker bypass attenuation 0dB or -10dB
// - Six-bit speaker gain, 1 dB steps
// - Speaker mute drives midrail level
// - Zero-cross bit defers gain change
// - Negative speaker output inverts positive
// - Pending gain applies after timeout
// - Timeout runs only with slow tick enable
// - Timeout has its own counter; slow tick serves debounce
// - Mono mixer sources: DAC, bypass, second mic
// - Mono bypass attenuation 0dB or -10dB
// - Mono mute drives midrail reference
module omc_output_mixer #(
  parameter integer SAMPLE_W = 16,
  parameter integer TIMEOUT_CYCLES = `OMC_TIMEOUT_PERIODS,
  parameter integer SLOW_TICK_CYCLES = `OMC_SLOW_TICK_PERIODS,
  parameter integer CNT_W = 22
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [6:0] reg_addr,
  input wire [8:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [8:0] reg_rdata,
  input wire sample_valid,
  input wire signed [SAMPLE_W-1:0] speaker_mix_sample,
  input wire signed [SAMPLE_W-1:0] single_mix_sample,
  input wire single_output_enable,
  output reg dac_to_speaker_select,
  output reg bypass_to_speaker_select,
  output reg second_mic_to_speaker_select,
  output reg speaker_bypass_attenuate,
  output reg [5:0] speaker_gain_code,
  output reg speaker_silence,
  output reg signed [SAMPLE_W-1:0] speaker_positive_out,
  output reg signed [SAMPLE_W-1:0] speaker_negative_out,
  output reg dac_to_single_select,
  output reg bypass_to_single_select,
  output reg second_mic_to_single_select,
  output reg single_bypass_attenuate,
  output reg single_output_silence,
  output reg signed [SAMPLE_W-1:0] single_output_pin,
  output reg gain_pending,
  output reg slow_tick
);
  localparam [SAMPLE_W-1:0] MIDRAIL = {SAMPLE_W{1'b0}};
  localparam integer TICK_LAST_INT = SLOW_TICK_CYCLES - 1;
  localparam [CNT_W-1:0] TICK_LAST = TICK_LAST_INT[CNT_W-1:0];
  // Reset images of the registers that feed output flops
  localparam [8:0] SPK_MIX_RESET = `OMC_RST_SPEAKER_MIXER;
  localparam [8:0] VOL_RESET = `OMC_RST_SPEAKER_VOLUME;
  localparam [8:0] MONO_MIX_RESET = `OMC_RST_MONO_MIXER;

  reg [8:0] additional_control_reg;
  reg [8:0] bypass_attenuation_control_reg;
  reg [8:0] speaker_mixer_select_reg;
  reg [8:0] speaker_volume_control_reg;
  reg [8:0] mono_mixer_control_reg;
  reg [CNT_W-1:0] tick_count_reg;
  reg [8:0] rdata_next;
  wire slow_en;
  wire add_write;
  wire byp_write;
  wire spk_mix_write;
  wire vol_write;
  wire mono_mix_write;
  wire [5:0] gain_now;
  wire pending_now;

  // Index decode shared by the write strobes and the read mux
  function hit;
    input [6:0] addr;
    input [6:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  assign slow_en = additional_control_reg[`OMC_BIT_SLOW_TICK_ENABLE];
  // Write strobes; unmapped indices hit none of them
  assign add_write = reg_write && hit(reg_addr, `OMC_ADDR_ADDITIONAL_CONTROL);
  assign byp_write = reg_write && hit(reg_addr, `OMC_ADDR_BYPASS_ATTENUATION);
  assign spk_mix_write = reg_write && hit(reg_addr, `OMC_ADDR_SPEAKER_MIXER);
  assign vol_write = reg_write && hit(reg_addr, `OMC_ADDR_SPEAKER_VOLUME);
  assign mono_mix_write = reg_write && hit(reg_addr, `OMC_ADDR_MONO_MIXER);

  // Control register bank
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      additional_control_reg <= `OMC_RST_ADDITIONAL_CONTROL;
      bypass_attenuation_control_reg <= `OMC_RST_BYPASS_ATTENUATION;
      speaker_mixer_select_reg <= `OMC_RST_SPEAKER_MIXER;
      speaker_volume_control_reg <= `OMC_RST_SPEAKER_VOLUME;
      mono_mixer_control_reg <= `OMC_RST_MONO_MIXER;
    end else begin
      if (add_write) begin
        additional_control_reg <= reg_wdata;
      end
      if (byp_write) begin
        bypass_attenuation_control_reg <= reg_wdata;
      end
      if (spk_mix_write) begin
        speaker_mixer_select_reg <= reg_wdata;
      end
      if (vol_write) begin
        speaker_volume_control_reg <= reg_wdata;
      end
      if (mono_mix_write) begin
        mono_mixer_control_reg <= reg_wdata;
      end
    end
  end

  // Read mux, captured into reg_rdata on reg_read
  always @* begin
    rdata_next = 9'h000;
    if (hit(reg_addr, `OMC_ADDR_ADDITIONAL_CONTROL)) begin
      rdata_next = additional_control_reg;
    end else if (hit(reg_addr, `OMC_ADDR_BYPASS_ATTENUATION)) begin
      rdata_next = bypass_attenuation_control_reg;
    end else if (hit(reg_addr, `OMC_ADDR_SPEAKER_MIXER)) begin
      rdata_next = speaker_mixer_select_reg;
    end else if (hit(reg_addr, `OMC_ADDR_SPEAKER_VOLUME)) begin
      rdata_next = speaker_volume_control_reg;
    end else if (hit(reg_addr, `OMC_ADDR_MONO_MIXER)) begin
      rdata_next = mono_mixer_control_reg;
    end
  end

  // Deferred speaker gain, applied on crossing or timeout
  omc_crossing_update #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
    .CNT_W(CNT_W)
  ) u_crossing (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .gain_write(vol_write),
    .gain_written(reg_wdata[`OMC_GAIN_MSB:0]),
    .crossing_only(speaker_volume_control_reg[`OMC_BIT_SPK_CROSSING]),
    .timeout_run(slow_en),
    .sample_valid(sample_valid),
    .sample_sign(speaker_mix_sample[SAMPLE_W-1]),
    .gain_applied_reg(gain_now),
    .pending_reg(pending_now)
  );

  // Slow tick shared with the jack debounce
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_count_reg <= {CNT_W{1'b0}};
      slow_tick <= 1'b0;
    end else if (!slow_en) begin
      tick_count_reg <= {CNT_W{1'b0}};
      slow_tick <= 1'b0;
    end else if (tick_count_reg == TICK_LAST) begin
      tick_count_reg <= {CNT_W{1'b0}};
      slow_tick <= 1'b1;
    end else begin
      tick_count_reg <= tick_count_reg + 1'b1;
      slow_tick <= 1'b0;
    end
  end

  // Output flops; every pin comes straight from a register
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_to_speaker_select <= SPK_MIX_RESET[`OMC_BIT_SPK_DAC_SEL];
      bypass_to_speaker_select <= 1'b0;
      second_mic_to_speaker_select <= 1'b0;
      speaker_bypass_attenuate <= 1'b0;
      speaker_gain_code <= VOL_RESET[`OMC_GAIN_MSB:0];
      speaker_silence <= 1'b0;
      speaker_positive_out <= MIDRAIL;
      speaker_negative_out <= MIDRAIL;
      dac_to_single_select <= MONO_MIX_RESET[`OMC_BIT_MONO_DAC_SEL];
      bypass_to_single_select <= 1'b0;
      second_mic_to_single_select <= 1'b0;
      single_bypass_attenuate <= 1'b0;
      single_output_silence <= 1'b0;
      single_output_pin <= MIDRAIL;
      gain_pending <= 1'b0;
      reg_rdata <= 9'h000;
    end else begin
      dac_to_speaker_select <= speaker_mixer_select_reg[`OMC_BIT_SPK_DAC_SEL];
      bypass_to_speaker_select <= speaker_mixer_select_reg[`OMC_BIT_SPK_BYPASS_SEL];
      second_mic_to_speaker_select <= speaker_mixer_select_reg[`OMC_BIT_SPK_SECOND_MICROPHONE_INPUT_SEL];
      speaker_bypass_attenuate <=
        bypass_attenuation_control_reg[`OMC_BIT_SPK_BYPASS_ATTEN];
      speaker_gain_code <= gain_now;
      speaker_silence <= speaker_volume_control_reg[`OMC_BIT_SPK_SILENCE];
      // Silence holds both speaker pins at midrail
      if (speaker_volume_control_reg[`OMC_BIT_SPK_SILENCE]) begin
        speaker_positive_out <= MIDRAIL;
        speaker_negative_out <= MIDRAIL;
      end else begin
        speaker_positive_out <= speaker_mix_sample;
        speaker_negative_out <= -speaker_mix_sample;
      end
      dac_to_single_select <= mono_mixer_control_reg[`OMC_BIT_MONO_DAC_SEL];
      bypass_to_single_select <= mono_mixer_control_reg[`OMC_BIT_MONO_BYPASS_SEL];
      second_mic_to_single_select <= mono_mixer_control_reg[`OMC_BIT_MONO_SECOND_MICROPHONE_INPUT_SEL];
      single_bypass_attenuate <=
        bypass_attenuation_control_reg[`OMC_BIT_MONO_BYPASS_ATTEN];
      single_output_silence <= mono_mixer_control_reg[`OMC_BIT_MONO_SILENCE];
      // Mono pin idles at midrail while disabled or silenced
      if (!single_output_enable || mono_mixer_control_reg[`OMC_BIT_MONO_SILENCE]) begin
        single_output_pin <= MIDRAIL;
      end else begin
        single_output_pin <= single_mix_sample;
      end
      gain_pending <= pending_now;
      if (reg_read) begin
        reg_rdata <= rdata_next;
      end
    end
  end
endmodule // omc_output_mixer

//--- dv/omc_output_mixer_properties.sv
module omc_output_mixer_properties #(parameter integer SAMPLE_W = 16) (
  input logic ref_clk,
  input logic rst_n,
  input logic [6:0] reg_addr,
  input logic [8:0] reg_wdata,
  input logic reg_write,
  input logic single_output_enable,
  input logic dac_to_speaker_select,
  input logic bypass_to_speaker_select,
  input logic second_mic_to_speaker_select,
  input logic speaker_bypass_attenuate,
  input logic [5:0] speaker_gain_code,
  input logic speaker_silence,
  input logic signed [SAMPLE_W-1:0] speaker_positive_out,
  input logic signed [SAMPLE_W-1:0] speaker_negative_out,
  input logic dac_to_single_select,
  input logic bypass_to_single_select,
  input logic second_mic_to_single_select,
  input logic single_bypass_attenuate,
  input logic single_output_silence,
  input logic signed [SAMPLE_W-1:0] single_output_pin,
  input logic gain_pending,
  input logic slow_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_SPK_SOURCES: assert property (reg_write && reg_addr == 7'h32 |-> ##2
    {second_mic_to_speaker_select, bypass_to_speaker_select, dac_to_speaker_select}
    == $past({reg_wdata[5], reg_wdata[1:0]}, 2)) else $error("speaker sources wrong");
  AST_MONO_SOURCES: assert property (reg_write && reg_addr == 7'h38 |-> ##2
    {second_mic_to_single_select, bypass_to_single_select, dac_to_single_select,
    single_output_silence} == $past({reg_wdata[2:0], reg_wdata[6]}, 2))
    else $error("mono sources wrong");
  AST_ATTEN: assert property (reg_write && reg_addr == 7'h28 |-> ##2
    {single_bypass_attenuate, speaker_bypass_attenuate} == $past(reg_wdata[2:1], 2))
    else $error("attenuation wrong");
  AST_SPK_SILENCE: assert property (reg_write && reg_addr == 7'h36 |-> ##2
    speaker_silence == $past(reg_wdata[6], 2)) else $error("speaker silence bit wrong");
  AST_SPK_MUTE: assert property (speaker_silence && $past(speaker_silence) |->
    speaker_positive_out == 0) else $error("speaker not at midrail");
  AST_NEG_INV: assert property (speaker_negative_out == -speaker_positive_out)
    else $error("negative output not inverted");
  AST_MONO_MUTE: assert property (single_output_silence && $past(single_output_silence) |->
    single_output_pin == 0) else $error("mono not at midrail");
  AST_MONO_OFF: assert property (!single_output_enable |=> single_output_pin == 0)
    else $error("mono active while disabled");
  AST_GAIN_HOLD: assert property (gain_pending && $past(gain_pending) |->
    $stable(speaker_gain_code)) else $error("gain changed while pending");
  AST_TICK_PULSE: assert property (slow_tick |=> !slow_tick [*8])
    else $error("slow tick too frequent");
  cover property ($fell(gain_pending));
  cover property (slow_tick);
  cover property (speaker_silence ##1 !speaker_silence);
endmodule // omc_output_mixer_properties

bind omc_output_mixer omc_output_mixer_properties #(.SAMPLE_W(SAMPLE_W)) u_props (
  .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .single_output_enable,
  .dac_to_speaker_select, .bypass_to_speaker_select, .second_mic_to_speaker_select,
  .speaker_bypass_attenuate, .speaker_gain_code, .speaker_silence, .speaker_positive_out,
  .speaker_negative_out, .dac_to_single_select, .bypass_to_single_select,
  .second_mic_to_single_select, .single_bypass_attenuate, .single_output_silence,
  .single_output_pin, .gain_pending, .slow_tick);

//--- dv/omc_output_mixer_bench.sv
module omc_output_mixer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_n = 0, reg_write = 0, reg_read = 0, sample_valid = 0;
  logic single_output_enable = 0, pend, tick, rd_pend = 0;
  logic [6:0] reg_addr = 0;
  logic [8:0] reg_wdata = 0, reg_rdata, d;
  logic signed [15:0] smp = 0, smp_q = 0, pos, neg, pin;
  logic [5:0] gain;
  logic [8:0] rd_q[$];
  logic [6:0] ra[6] = '{7'h07, 7'h28, 7'h32, 7'h36, 7'h38, 7'h00};
  logic [8:0] rv[6] = '{9'h000, 9'h000, 9'h001, 9'h039, 9'h001, 9'h000};
  logic [5:0] gc[3] = '{6'h3f, 6'h00, 6'h39};
  int n_errors = 0, compares = 0, n_tick = 0, t0;
  omc_output_mixer #(.TIMEOUT_CYCLES(16), .SLOW_TICK_CYCLES(16)) dut (
    .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .sample_valid, .speaker_mix_sample(smp_q), .single_mix_sample(smp_q), .single_output_enable,
    .dac_to_speaker_select(), .bypass_to_speaker_select(), .second_mic_to_speaker_select(),
    .speaker_bypass_attenuate(), .speaker_gain_code(gain), .speaker_silence(),
    .speaker_positive_out(pos), .speaker_negative_out(neg), .dac_to_single_select(),
    .bypass_to_single_select(), .second_mic_to_single_select(), .single_bypass_attenuate(),
    .single_output_silence(), .single_output_pin(pin), .gain_pending(pend), .slow_tick(tick));
  initial forever #2 ref_clk = ~ref_clk;
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(logic [6:0] a, logic [8:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(logic [6:0] a, logic [8:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    rd_q.push_back(e);
    @(posedge ref_clk);
    reg_read <= 1'b0;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Sample feed and read-data monitor
  always @(posedge ref_clk) begin
    sample_valid <= rst_n;
    smp_q <= smp;
    if (tick) n_tick++;
    if (rd_pend) chk("reg_rdata", reg_rdata, rd_q.pop_front());
    rd_pend <= reg_read;
  end
  initial begin
    #80000;
    n_errors++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'h3010));
    cyc(16);
    rst_n <= 1'b1;
    smp = 16'sh0064;
    foreach (ra[i]) rd(ra[i], rv[i]);
    for (int i = 0; i < 9; i++) begin
      d = 9'($urandom);
      wr(ra[i % 3 == 0 ? 1 : i % 3 == 1 ? 2 : 4], d);
      rd(ra[i % 3 == 0 ? 1 : i % 3 == 1 ? 2 : 4], d);
    end
    foreach (gc[i]) begin
      wr(7'h36, {3'h0, gc[i]});
      cyc(3);
      chk("speaker_gain_code", gain, gc[i]);
    end
    wr(7'h36, 9'h079);
    cyc(4);
    chk("speaker_positive_out", pos, 16'h0000);
    wr(7'h36, 9'h039);
    smp = 16'($urandom_range(1, 32767));
    cyc(5);
    chk("speaker_negative_out", neg, -smp);
    single_output_enable <= 1'b1;
    wr(7'h38, 9'h041);
    cyc(4);
    chk("single_output_pin", pin, 16'h0000);
    wr(7'h38, 9'h001);
    cyc(4);
    chk("single_output_pin", pin, smp);
    single_output_enable <= 1'b0;
    cyc(3);
    chk("single_output_pin", pin, 16'h0000);
    // Deferred gain released by a sign change
    wr(7'h36, 9'h0b9);
    wr(7'h36, 9'h0a0);
    cyc(6);
    chk("gain_pending", pend, 16'h0001);
    smp = -16'sh0064;
    cyc(5);
    chk("speaker_gain_code", gain, 16'h0020);
    smp = 16'sh0064;
    cyc(3);
    // Deferred gain released by the timeout only when enabled
    wr(7'h36, 9'h0a5);
    cyc(40);
    chk("gain_pending", pend, 16'h0001);
    wr(7'h07, 9'h001);
    cyc(10);
    chk("gain_pending", pend, 16'h0001);
    cyc(16);
    chk("speaker_gain_code", gain, 16'h0025);
    // A rewrite while pending restarts the wait
    wr(7'h36, 9'h0a7);
    cyc(10);
    wr(7'h36, 9'h0a9);
    cyc(10);
    chk("gain_pending", pend, 16'h0001);
    cyc(16);
    chk("speaker_gain_code", gain, 16'h0029);
    t0 = n_tick;
    cyc(48);
    chk("slow_tick count", 16'(n_tick - t0), 16'h0003);
    wr(7'h07, 9'h000);
    cyc(2);
    t0 = n_tick;
    cyc(48);
    chk("slow_tick count", 16'(n_tick - t0), 16'h0000);
    end_of_test;
  end
endmodule // omc_output_mixer_bench
